// ===== src/jesd_link_control_pkg.sv
// Register map, reset values and constants of the link control register bank
package jesd_link_control_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [11:0] LINK_ENABLE_ADDR       = 12'h200;
    localparam logic [11:0] OUTPUT_MODE_ADDR       = 12'h201;
    localparam logic [11:0] FRAMES_PER_MF_ADDR     = 12'h202;
    localparam logic [11:0] SW_SYNC_REQUEST_ADDR   = 12'h203;
    localparam logic [11:0] LINK_CONTROL_ADDR      = 12'h204;
    localparam logic [11:0] CAL_CONTROL_ADDR       = 12'h210;
    localparam logic [11:0] LINK_STATUS_ADDR       = 12'h211;

    // Reset values
    localparam logic       LINK_ENABLE_RST         = 1'h1;
    localparam logic [5:0] OUTPUT_MODE_RST         = 6'h00;
    localparam logic [7:0] FRAMES_PER_MF_RST       = 8'h1F;
    localparam logic       SW_SYNC_REQUEST_RST     = 1'h1;
    localparam logic [4:0] LINK_CONTROL_RST        = 5'h03;
    localparam logic       CAL_ENABLE_RST          = 1'h0;

    // Link control field positions
    localparam int CTRL_SCRAMBLER_BIT   = 0;
    localparam int CTRL_FORMAT_BIT      = 1;
    localparam int CTRL_SYNC_SEL_LO     = 2;
    localparam int CTRL_SYNC_SEL_HI     = 3;
    localparam int CTRL_UPPER_LANES_BIT = 4;

    // Sync source encodings
    localparam logic [1:0] SYNC_SEL_PIN       = 2'h0;
    localparam logic [1:0] SYNC_SEL_TIMESTAMP = 2'h1;
    localparam logic [1:0] SYNC_SEL_NONE      = 2'h2;

    // Lane mapping
    localparam int          NUM_LANES        = 8;
    localparam logic [3:0]  UPPER_LANE_BASE  = 4'h4;
    localparam logic [3:0]  UPPER_LANE_MAX_L = 4'h4;

    // Multiframe counter
    localparam int          MFC_W            = 12;
    localparam logic [11:0] BLOCK_MF_FACTOR  = 12'h100;

    typedef enum logic [1:0] {
        LINK_OFF,
        LINK_SYNC,
        LINK_DATA
    } link_state_e;

endpackage

// ===== src/jesd_link_control_regs.sv
// Link control register bank with enable, sync request and multiframe counter
//
// Contract
// - Link enable low holds link block in reset, serializers powered down.
// - Link enable low gates off the link block clocks.
// - Link disabled holds multiframe counter reset; SYSREF does not align it.
// - Six-bit output mode field; changed only with link and calibration off.
// - Eight-bit frames per multiframe less one, reset 0x1F meaning 32.
// - In 64B/66B modes effective frame count is 256 times E over F.
// - Software sync bit zero requests sync like SYNC~; resets to one.
// - Software sync request works whatever sync source is selected.
// - Stuck low sync pin keeps request until sync source set to 2.
// - Link control resets 0x03: scrambler, format one; sync select, lanes zero.
// - Sample format zero is offset binary, one is two's complement.
// - Sync source 0 sync pin, 1 timestamp pair, 2 software only.
// - Upper lane bit uses lanes 4 to 4+L-1, only when L at most 4.
// - Scrambler bit applies to 8B/10B only; 64B/66B always scrambles.
module jesd_link_control_regs
    import jesd_link_control_pkg::*;
#(
    parameter int SAMPLE_W = 9
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  srst_i,
    // Register port
    input  wire logic [ADDR_W-1:0]     reg_addr_i,
    input  wire logic [DATA_W-1:0]     reg_wdata_i,
    input  wire logic                  reg_write_i,
    input  wire logic                  reg_read_i,
    output logic      [DATA_W-1:0]     reg_rdata_o,
    // Mode parameters from the mode decoder
    input  wire logic                  mode_is_64b66b_i,
    input  wire logic [3:0]            octets_per_block_i,
    input  wire logic [7:0]            octets_per_frame_i,
    input  wire logic [3:0]            lane_count_i,
    // Pins
    input  wire logic                  sync_input_pin_n_i,
    input  wire logic                  timestamp_input_pair_n_i,
    input  wire logic                  sysref_i,
    // Link side
    input  wire logic                  frame_tick_i,
    input  wire logic [SAMPLE_W-1:0]   sample_i,
    output logic      [SAMPLE_W-1:0]   sample_o,
    output logic                       link_reset_o,
    output logic                       link_clock_enable_o,
    output logic                       link_restart_o,
    output logic                       sync_request_o,
    output logic      [1:0]            link_state_o,
    output logic      [NUM_LANES-1:0]  lane_enable_o,
    output logic      [NUM_LANES-1:0]  lane_power_down_o,
    output logic                       scrambler_active_o,
    output logic      [5:0]            output_mode_select_o,
    output logic      [MFC_W-1:0]      multiframe_clock_counter_o,
    output logic                       multiframe_start_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Last frame index of a multiframe
    function automatic logic [MFC_W-1:0] last_frame(
        input logic            is_block,
        input logic [7:0]      km1,
        input logic [3:0]      e_oct,
        input logic [7:0]      f_oct
    );
        logic [MFC_W-1:0] k_blk;
        k_blk = '0;
        if (is_block && f_oct != 8'h00) begin
            k_blk = MFC_W'((BLOCK_MF_FACTOR * MFC_W'(e_oct)) / MFC_W'(f_oct));
        end
        if (!is_block) begin
            return MFC_W'(km1);
        end else if (k_blk == '0) begin
            return '0;
        end else begin
            return k_blk - MFC_W'(1);
        end
    endfunction

    // Mask of L low lanes
    function automatic logic [NUM_LANES-1:0] lane_mask(input logic [3:0] lanes);
        logic [NUM_LANES-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_LANES; i++) begin
            if (4'(i) < lanes) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic                   link_enable;
    logic [5:0]             output_mode_select;
    logic [7:0]             frames_per_multiframe_less_one;
    logic                   software_sync_request_n;
    logic [4:0]             link_control;
    logic                   cal_enable;
    logic                   link_enable_q;
    link_state_e            link_state;
    link_state_e            next_link_state;

    wire hit_enable  = reg_addr_i == LINK_ENABLE_ADDR;
    wire hit_mode    = reg_addr_i == OUTPUT_MODE_ADDR;
    wire hit_km1     = reg_addr_i == FRAMES_PER_MF_ADDR;
    wire hit_swsync  = reg_addr_i == SW_SYNC_REQUEST_ADDR;
    wire hit_control = reg_addr_i == LINK_CONTROL_ADDR;
    wire hit_cal     = reg_addr_i == CAL_CONTROL_ADDR;
    wire hit_status  = reg_addr_i == LINK_STATUS_ADDR;

    // Mode write accepted only with link and calibration both off
    wire mode_write_ok = !link_enable && !cal_enable;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            link_enable                    <= LINK_ENABLE_RST;
            output_mode_select             <= OUTPUT_MODE_RST;
            frames_per_multiframe_less_one <= FRAMES_PER_MF_RST;
            software_sync_request_n        <= SW_SYNC_REQUEST_RST;
            link_control                   <= LINK_CONTROL_RST;
            cal_enable                     <= CAL_ENABLE_RST;
        end else if (reg_write_i) begin
            if (hit_enable) begin
                link_enable <= reg_wdata_i[0];
            end else if (hit_mode && mode_write_ok) begin
                output_mode_select <= reg_wdata_i[5:0];
            end else if (hit_km1) begin
                frames_per_multiframe_less_one <= reg_wdata_i;
            end else if (hit_swsync) begin
                software_sync_request_n <= reg_wdata_i[0];
            end else if (hit_control) begin
                link_control <= reg_wdata_i[4:0];
            end else if (hit_cal) begin
                cal_enable <= reg_wdata_i[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    wire [DATA_W-1:0] status_word = {4'h0, cal_enable, sync_request_o, link_state_o};

    wire [DATA_W-1:0] read_mux =
        hit_enable  ? {7'h00, link_enable} :
        hit_mode    ? {2'h0, output_mode_select} :
        hit_km1     ? frames_per_multiframe_less_one :
        hit_swsync  ? {7'h00, software_sync_request_n} :
        hit_control ? {3'h0, link_control} :
        hit_cal     ? {7'h00, cal_enable} :
        hit_status  ? status_word :
                      8'h00;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= reg_read_i ? read_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [1:0] sync_pin_sync;
    logic [1:0] timestamp_input_pair_sync;
    logic [1:0] sysref_sync;
    logic       sysref_prev;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sync_pin_sync <= 2'h3;
            timestamp_input_pair_sync    <= 2'h3;
            sysref_sync   <= 2'h0;
            sysref_prev   <= 1'b0;
        end else begin
            sync_pin_sync <= {sync_pin_sync[0], sync_input_pin_n_i};
            timestamp_input_pair_sync    <= {timestamp_input_pair_sync[0], timestamp_input_pair_n_i};
            sysref_sync   <= {sysref_sync[0], sysref_i};
            sysref_prev   <= sysref_sync[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync request

    wire [1:0] sync_sel = link_control[CTRL_SYNC_SEL_HI:CTRL_SYNC_SEL_LO];

    // Pin request; sync select 2 (and 3) ignores both pins
    wire pin_request =
        (sync_sel == SYNC_SEL_PIN)       ? !sync_pin_sync[1] :
        (sync_sel == SYNC_SEL_TIMESTAMP) ? !timestamp_input_pair_sync[1]    :
                                           1'b0;

    // Software bit acts under every source
    wire any_request = !software_sync_request_n || pin_request;

    ////////////////////////////////////////////////////////////////////////////
    // Link enable, reset and restart

    wire link_rise = link_enable && !link_enable_q;

    always_comb begin
        next_link_state = link_state;
        case (link_state)
            LINK_OFF: begin
                if (link_enable) begin
                    next_link_state = LINK_SYNC;
                end
            end
            LINK_SYNC: begin
                if (!any_request) begin
                    next_link_state = LINK_DATA;
                end
            end
            LINK_DATA: begin
                if (any_request) begin
                    next_link_state = LINK_SYNC;
                end
            end
            default: begin
                next_link_state = LINK_OFF;
            end
        endcase
        if (!link_enable) begin
            next_link_state = LINK_OFF;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            link_enable_q <= 1'b0;
            link_state    <= LINK_OFF;
        end else begin
            link_enable_q <= link_enable;
            link_state    <= next_link_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Multiframe clock counter

    wire [MFC_W-1:0] mf_last = last_frame(mode_is_64b66b_i, frames_per_multiframe_less_one,
                                          octets_per_block_i, octets_per_frame_i);
    wire sysref_edge = sysref_sync[1] && !sysref_prev;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || !link_enable) begin
            multiframe_clock_counter_o <= '0;
            multiframe_start_o         <= 1'b0;
        end else if (sysref_edge) begin
            multiframe_clock_counter_o <= '0;
            multiframe_start_o         <= 1'b1;
        end else if (frame_tick_i) begin
            if (multiframe_clock_counter_o >= mf_last) begin
                multiframe_clock_counter_o <= '0;
                multiframe_start_o         <= 1'b1;
            end else begin
                multiframe_clock_counter_o <= multiframe_clock_counter_o + MFC_W'(1);
                multiframe_start_o         <= 1'b0;
            end
        end else begin
            multiframe_start_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lane mapping and configuration outputs

    wire upper_ok = link_control[CTRL_UPPER_LANES_BIT] && (lane_count_i <= UPPER_LANE_MAX_L);
    wire [NUM_LANES-1:0] base_mask = lane_mask(lane_count_i);
    wire [NUM_LANES-1:0] mapped_mask = upper_ok ? (base_mask << UPPER_LANE_BASE)
                                                : base_mask;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || !link_enable) begin
            link_reset_o         <= 1'b1;
            link_clock_enable_o  <= 1'b0;
            link_restart_o       <= 1'b0;
            sync_request_o       <= 1'b0;
            lane_enable_o        <= '0;
            lane_power_down_o    <= '1;
            scrambler_active_o   <= 1'b0;
            sample_o             <= '0;
        end else begin
            link_reset_o         <= 1'b0;
            link_clock_enable_o  <= 1'b1;
            link_restart_o       <= link_rise;
            sync_request_o       <= any_request;
            lane_enable_o        <= mapped_mask;
            lane_power_down_o    <= ~mapped_mask;
            scrambler_active_o   <= mode_is_64b66b_i
                                    || link_control[CTRL_SCRAMBLER_BIT];
            sample_o             <= link_control[CTRL_FORMAT_BIT] ? sample_i
                                    : {~sample_i[SAMPLE_W-1], sample_i[SAMPLE_W-2:0]};
        end
    end

    assign link_state_o         = link_state;
    assign output_mode_select_o = output_mode_select;

endmodule

// ===== tb/jesd_link_control_regs_asserts.sv
// Port checks of the link control register bank
module jesd_link_control_regs_asserts
    import jesd_link_control_pkg::*;
(
    input wire logic                 ref_clk_i,
    input wire logic                 srst_i,
    input wire logic                 mode_is_64b66b_i,
    input wire logic                 frame_tick_i,
    input wire logic                 link_reset_o,
    input wire logic                 link_clock_enable_o,
    input wire logic                 link_restart_o,
    input wire logic [NUM_LANES-1:0] lane_enable_o,
    input wire logic [NUM_LANES-1:0] lane_power_down_o,
    input wire logic                 scrambler_active_o,
    input wire logic [5:0]           output_mode_select_o,
    input wire logic [MFC_W-1:0]     multiframe_clock_counter_o,
    input wire logic                 multiframe_start_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_off_state;
        link_reset_o |-> lane_power_down_o == 8'hFF && !scrambler_active_o;
    endproperty
    a_off_state: assert property (p_off_state)
        else $error("lanes or scrambler live while link off");
    property p_clock_gate;
        1'b1 |-> link_clock_enable_o != link_reset_o;
    endproperty
    a_clock_gate: assert property (p_clock_gate)
        else $error("clock enable disagrees with link reset");
    property p_counter_held;
        link_reset_o |-> multiframe_clock_counter_o == 12'h000 && !multiframe_start_o;
    endproperty
    a_counter_held: assert property (p_counter_held)
        else $error("counter moved while link off");
    property p_restart;
        $fell(link_reset_o) |-> link_restart_o ##1 !link_restart_o;
    endproperty
    a_restart: assert property (p_restart)
        else $error("no single restart pulse on enable");
    property p_restart_cause;
        link_restart_o |-> $past(link_reset_o);
    endproperty
    a_restart_cause: assert property (p_restart_cause)
        else $error("restart pulse without prior disable");
    property p_lane_mask;
        1'b1 |-> lane_power_down_o == ~lane_enable_o;
    endproperty
    a_lane_mask: assert property (p_lane_mask)
        else $error("power down not inverse of lane mask");
    property p_scrambler_64;
        !link_reset_o && !$past(link_reset_o) && $past(mode_is_64b66b_i) |-> scrambler_active_o;
    endproperty
    a_scrambler_64: assert property (p_scrambler_64)
        else $error("block mode running unscrambled");
    sequence s_running;
        !link_reset_o && !$past(link_reset_o) && !multiframe_start_o;
    endsequence
    property p_counter_stable;
        s_running and !$past(frame_tick_i) |-> $stable(multiframe_clock_counter_o);
    endproperty
    a_counter_stable: assert property (p_counter_stable)
        else $error("counter moved without frame tick");
    property p_counter_step;
        s_running and $past(frame_tick_i) |->
            multiframe_clock_counter_o == $past(multiframe_clock_counter_o) + 12'h001;
    endproperty
    a_counter_step: assert property (p_counter_step)
        else $error("counter did not step by one");
    property p_mode_stable;
        !link_reset_o && !$past(link_reset_o) |-> $stable(output_mode_select_o);
    endproperty
    a_mode_stable: assert property (p_mode_stable)
        else $error("mode changed while link on");
    c_restart: cover property (link_restart_o);
    c_wrap: cover property (multiframe_start_o && $past(frame_tick_i));
    c_mode: cover property (!$stable(output_mode_select_o));
endmodule

// ===== tb/jesd_link_control_regs_tb_top.sv
// Self-checking bench for the link control register bank
module jesd_link_control_regs_tb_top import jesd_link_control_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i, srst_i, reg_write_i, reg_read_i, mode_is_64b66b_i, sysref_i, frame_tick_i;
    logic pin_req, ts_req, link_reset_o, link_clock_enable_o, link_restart_o, sync_request_o;
    logic scrambler_active_o, multiframe_start_o, sync_input_pin_n_i, timestamp_input_pair_n_i;
    logic [11:0] reg_addr_i, multiframe_clock_counter_o;
    logic [7:0]  reg_wdata_i, octets_per_frame_i, reg_rdata_o, lane_enable_o, lane_power_down_o;
    logic [3:0]  octets_per_block_i, lane_count_i;
    logic [8:0]  sample_i, sample_o;
    logic [5:0]  output_mode_select_o;
    logic [1:0]  link_state_o;
    logic [7:0]  k, c;
    int          error_cnt, checks, kk;
    jesd_link_control_regs jesd_link_control_regs_i (.ref_clk_i, .srst_i, .reg_addr_i,
        .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .mode_is_64b66b_i,
        .octets_per_block_i, .octets_per_frame_i, .lane_count_i, .sync_input_pin_n_i,
        .timestamp_input_pair_n_i, .sysref_i, .frame_tick_i, .sample_i, .sample_o,
        .link_reset_o, .link_clock_enable_o, .link_restart_o, .sync_request_o, .link_state_o,
        .lane_enable_o, .lane_power_down_o, .scrambler_active_o, .output_mode_select_o,
        .multiframe_clock_counter_o, .multiframe_start_o);
    jesd_link_far_end_model jesd_link_far_end_model_i (.ref_clk_i, .pin_req_i(pin_req),
        .ts_req_i(ts_req), .sync_input_pin_n_o(sync_input_pin_n_i),
        .timestamp_input_pair_n_o(timestamp_input_pair_n_i));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_lanes(input logic up, input logic [3:0] l);
        return ((8'h01 << l) - 8'h01) << (up ? 4 : 0);
    endfunction
    function automatic logic [8:0] exp_sample(input logic fmt, input logic [8:0] s);
        return fmt ? s : {~s[8], s[7:0]};
    endfunction
    function automatic int exp_k(input logic b, input logic [7:0] km, input int e, input int f);
        return b ? 256 * e / f : km + 1;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_read_i <= 1'b0;
        #1;
        check(reg_rdata_o, exp);
    endtask
    task automatic pulse_sysref();
        @(posedge ref_clk_i);
        sysref_i <= 1'b1;
        @(posedge ref_clk_i);
        sysref_i <= 1'b0;
        settle(6);
    endtask
    task automatic reconfig(input logic [5:0] m, input logic [7:0] km, input logic [7:0] ctl);
        logic ok;
        ok = 1'b0;
        wr(LINK_ENABLE_ADDR, 8'h00);
        wr(CAL_CONTROL_ADDR, 8'h00);
        pulse_sysref();
        check(multiframe_clock_counter_o, 12'h000);
        check({link_reset_o, link_clock_enable_o, link_state_o}, 4'h8);
        check(lane_power_down_o, 8'hFF);
        wr(OUTPUT_MODE_ADDR, {2'h0, m});
        rd(OUTPUT_MODE_ADDR, {2'h0, m});
        wr(FRAMES_PER_MF_ADDR, km);
        wr(LINK_CONTROL_ADDR, ctl);
        wr(CAL_CONTROL_ADDR, 8'h01);
        wr(LINK_ENABLE_ADDR, 8'h01);
        repeat (4) begin
            settle(1);
            ok |= link_restart_o;
        end
        check(ok, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #400us;
        error_cnt++;
        complete_run();
    end
    initial begin
        {srst_i, reg_write_i, reg_read_i, mode_is_64b66b_i, sysref_i, frame_tick_i} = 6'h20;
        {pin_req, ts_req, reg_addr_i, reg_wdata_i, sample_i} = '0;
        {octets_per_block_i, octets_per_frame_i, lane_count_i} = {4'h1, 8'h08, 4'h1};
        error_cnt = 0;
        checks = 0;
        void'($urandom(72372));
        repeat (8) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        rd(LINK_ENABLE_ADDR, 8'h01);
        rd(FRAMES_PER_MF_ADDR, 8'h1F);
        rd(SW_SYNC_REQUEST_ADDR, 8'h01);
        rd(LINK_CONTROL_ADDR, 8'h03);
        rd(12'h3FF, 8'h00);
        wr(OUTPUT_MODE_ADDR, 8'h2A);
        rd(OUTPUT_MODE_ADDR, 8'h00);
        $display("test reset values done");
        for (int n = 0; n < 6; n++) begin
            @(posedge ref_clk_i);
            mode_is_64b66b_i <= 1'(n > 1 ? $urandom_range(1) : 0);
            octets_per_block_i <= 4'($urandom_range(2, 1));
            lane_count_i <= 4'($urandom_range(4, 1));
            sample_i <= 9'($urandom);
            k = n < 2 ? (n == 0 ? 8'h00 : 8'hFF) : 8'($urandom_range(12, 3));
            c = {3'h0, 1'($urandom_range(1)), 2'h2, 2'($urandom_range(3))};
            reconfig(6'($urandom), k, c);
            settle(2);
            check(link_state_o, LINK_DATA);
            rd(LINK_STATUS_ADDR, 8'h0A);
            check(lane_enable_o, exp_lanes(c[4], lane_count_i));
            check(scrambler_active_o, mode_is_64b66b_i | c[0]);
            check(sample_o, exp_sample(c[1], sample_i));
            kk = exp_k(mode_is_64b66b_i, k, octets_per_block_i, octets_per_frame_i);
            pulse_sysref();
            check(multiframe_clock_counter_o, 12'h000);
            repeat (kk + 2) begin
                @(posedge ref_clk_i);
                frame_tick_i <= 1'b1;
                @(posedge ref_clk_i);
                frame_tick_i <= 1'b0;
            end
            settle(3);
            check(multiframe_clock_counter_o, 12'((kk + 2) % kk));
        end
        $display("test configurations done");
        for (int s = 0; s < 3; s++) begin
            reconfig(6'h00, 8'h1F, {3'h0, 1'b0, s[1:0], 2'h3});
            for (int p = 0; p < 2; p++) begin
                @(posedge ref_clk_i);
                pin_req <= (p == 0);
                ts_req <= (p == 1);
                settle(6);
                check(sync_request_o, s == p);
            end
            @(posedge ref_clk_i);
            ts_req <= 1'b0;
            wr(SW_SYNC_REQUEST_ADDR, 8'h00);
            settle(6);
            check({sync_request_o, link_state_o}, {1'b1, LINK_SYNC});
            wr(SW_SYNC_REQUEST_ADDR, 8'h01);
            settle(6);
            check(sync_request_o, 1'b0);
        end
        $display("test sync sources done");
        complete_run();
    end
endmodule
bind jesd_link_control_regs jesd_link_control_regs_asserts jesd_link_control_regs_asserts_i (
    .ref_clk_i, .srst_i, .mode_is_64b66b_i, .frame_tick_i, .link_reset_o, .link_clock_enable_o,
    .link_restart_o, .lane_enable_o, .lane_power_down_o, .scrambler_active_o,
    .output_mode_select_o, .multiframe_clock_counter_o, .multiframe_start_o);

// ===== tb/jesd_link_far_end_model.sv
// Far end receiver model driving the active low sync request lines
module jesd_link_far_end_model (
    input  wire logic ref_clk_i,
    input  wire logic pin_req_i,
    input  wire logic ts_req_i,
    output logic      sync_input_pin_n_o,
    output logic      timestamp_input_pair_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sync_input_pin_n_o = 1'b1;
        timestamp_input_pair_n_o = 1'b1;
    end
    // Lines idle high, pulled low to ask for sync
    always @(posedge ref_clk_i) begin
        sync_input_pin_n_o <= !pin_req_i;
        timestamp_input_pair_n_o <= !ts_req_i;
    end
endmodule
